/* logic/bst_pkg.sv */
// Notes on behaviour
// - Control-status register is 8 bits; bits 7:6 reserved; rest clear on reset/disable.
// - Module-busy bit 0 set while starting, master, addressed slave or receiving address.
// - After the address byte, go idle or enter slave mode per match.
// - Module-busy clears when all causes end or on disable; writes ignored.
// - Lines sampled while enabled; bus-busy bit 1 set on any low line or start.
// - Bus-busy holds until stop, write of 1, or disable; write 0 ignored.
// - Address-match bit 2 sets when 7 address bits equal an enabled own address.
// - Address-match clears on any start, repeated start or stop, legal or not.
// - General-call bit 3 sets in slave mode, enabled, on address byte zero.
// - General-call clears on any start, repeated start or stop.
// - Bit 4 reads the sampled data line level; writes ignored.
// - Writing 1 to bit 5 with data low drives clock high one cycle.
// - Toggle write with data high ignored; writing 0 does nothing.
// - Toggle bit reads 1 while toggling, clears itself when done.
// - Clearing enable disables module, clears control/status, halts line logic.
// - With general call disabled, address byte zero gets no response.
package bst_pkg;
  localparam logic [7:0] OFS_CST   = 8'h00;
  localparam logic [7:0] OFS_CTL1  = 8'h04;
  localparam logic [7:0] OFS_CTL2  = 8'h08;
  localparam logic [7:0] OFS_OADR1 = 8'h0c;
  localparam logic [7:0] OFS_OADR2 = 8'h10;
  localparam logic [7:0] OFS_IST   = 8'h14;
  localparam logic [7:0] OFS_IMSK  = 8'h18;

  localparam int CST_BUSY  = 0;
  localparam int CST_BB    = 1;
  localparam int CST_MATCH = 2;
  localparam int CST_GCM   = 3;
  localparam int CST_DATA_LINE_SAMPLE  = 4;
  localparam int CST_TGL   = 5;

  localparam int CTL1_GENERAL_CALL_ENABLE = 5;
  localparam int CTL2_EN    = 0;
  localparam int OADR_SLAVE_ADDRESS_ENABLE  = 7;

  localparam int IRQ_START = 0;
  localparam int IRQ_STOP  = 1;
  localparam int IRQ_MATCH = 2;
  localparam int IRQ_GCALL = 3;
  localparam int IRQ_TGL   = 4;
  localparam int IRQ_W     = 5;

  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [7:0] GCALL_ADR = 8'h00;
  localparam logic [3:0] LAST_BIT  = 4'h7;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ADDR  = 3'b010,
    ST_SLAVE = 3'b100
  } bst_slv_state_t;
endpackage

/* logic/bst_line_if.sv */
`timescale 1ns/1ps
interface bst_line_if;
  logic       sda_lvl;
  logic       scl_lvl;
  logic       start_p;
  logic       stop_p;
  logic       byte_p;
  logic [7:0] byte_val;
  modport mon (output sda_lvl, scl_lvl, start_p, stop_p, byte_p, byte_val);
  modport sink (input sda_lvl, scl_lvl, start_p, stop_p, byte_p, byte_val);
endinterface

/* logic/bst_line_mon.sv */
`timescale 1ns/1ps
module bst_line_mon
  import bst_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic clr,
  input  wire logic sda_i,
  input  wire logic scl_i,
  bst_line_if.mon   lm
);
  typedef struct packed {
    logic [1:0][2:0] sy;
    logic [1:0]      lvl;
    logic            act;
    logic [3:0]      cnt;
    logic [7:0]      sh;
    logic            start_p;
    logic            stop_p;
    logic            byte_p;
  } bst_mon_st_t;

  localparam bst_mon_st_t M_RST = '{sy: '1, lvl: '1, default: '0};

  bst_mon_st_t q;
  bst_mon_st_t n;
  logic [1:0]  pin;

  assign pin = {scl_i, sda_i};

  always_comb begin
    n = q;
    n.start_p = 1'b0;
    n.stop_p  = 1'b0;
    n.byte_p  = 1'b0;
    // Three-stage sampling, level accepted when stages 2 and 3 agree
    for (int i = 0; i < 2; i++) begin
      n.sy[i] = {q.sy[i][1:0], pin[i]};
      if (q.sy[i][1] == q.sy[i][2]) begin
        n.lvl[i] = q.sy[i][2];
      end
    end
    if (q.lvl[1] && n.lvl[1] && q.lvl[0] && !n.lvl[0]) begin
      n.start_p = 1'b1;
      n.act     = 1'b1;
      n.cnt     = 4'h0;
    end else if (q.lvl[1] && n.lvl[1] && !q.lvl[0] && n.lvl[0]) begin
      n.stop_p = 1'b1;
      n.act    = 1'b0;
    end else if (q.act && !q.lvl[1] && n.lvl[1]) begin
      // First bit lands in bit 7
      n.sh  = {q.sh[6:0], q.lvl[0]};
      n.cnt = q.cnt + 4'h1;
      if (q.cnt == LAST_BIT) begin
        n.byte_p = 1'b1;
        n.act    = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst || clr) begin
      q <= M_RST;
    end else begin
      q <= n;
    end
  end

  assign lm.sda_lvl  = q.lvl[0];
  assign lm.scl_lvl  = q.lvl[1];
  assign lm.start_p  = q.start_p;
  assign lm.stop_p   = q.stop_p;
  assign lm.byte_p   = q.byte_p;
  assign lm.byte_val = q.sh;
endmodule

/* logic/bst_top.sv */
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/1ps
module bst_top
  import bst_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        start_gen_i,
  input  wire logic        master_i,
  input  wire logic        sda_i,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  output logic             module_busy_o,
  output logic             irq_o
);
  typedef struct packed {
    bst_slv_state_t   st;
    logic             match;
    logic             gcm;
    logic             bb;
    logic             tgl;
    logic             drv;
    logic [7:0]       ctl1;
    logic [7:0]       ctl2;
    logic [7:0]       oa1;
    logic [7:0]       oa2;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imsk;
    logic             busy;
    logic             irq;
    logic             ack;
    logic [31:0]      dat;
    logic             scl_o;
    logic             scl_oe;
  } bst_top_st_t;

  localparam bst_top_st_t T_RST = '{st: ST_IDLE, default: '0};

  bst_top_st_t q;
  bst_top_st_t n;
  bst_line_if  lm ();

  bst_line_mon u_mon (
    .clk   (clk),
    .srst  (srst),
    .clr   (!q.ctl2[CTL2_EN]),
    .sda_i (sda_i),
    .scl_i (scl_i),
    .lm    (lm)
  );

  function automatic logic addr_hit(input logic [7:0] rx,
                                    input logic [7:0] own);
    addr_hit = own[OADR_SLAVE_ADDRESS_ENABLE] && (own[6:0] == rx[7:1]);
  endfunction

  logic       wr;
  logic       rd;
  logic [7:0] wd;
  logic       hit;
  logic       gh;
  logic [7:0] cst;

  always_comb begin
    n     = q;
    n.ack = 1'b0;
    wr    = wb_cyc_i && wb_stb_i && wb_we_i && q.ack && wb_sel_i[0];
    rd    = wb_cyc_i && wb_stb_i && !q.ack;
    wd    = wb_dat_i[7:0];
    hit   = 1'b0;
    gh    = 1'b0;
    // Line sample reads 0 while disabled
    cst   = {2'b00, q.tgl, q.ctl2[CTL2_EN] && lm.sda_lvl,
             q.gcm, q.match, q.bb, q.busy};

    // Software writes; module-busy and line sample take no write
    if (wr) begin
      case (wb_adr_i)
        OFS_CST: begin
          if (wd[CST_BB]) begin
            n.bb = 1'b0;
          end
          if (wd[CST_TGL] && !lm.sda_lvl && !q.tgl) begin
            n.tgl = 1'b1;
          end
        end
        OFS_CTL1:  n.ctl1 = wd;
        OFS_CTL2:  n.ctl2 = wd;
        OFS_OADR1: n.oa1  = wd;
        OFS_OADR2: n.oa2  = wd;
        OFS_IST:   n.ist  = q.ist & ~wd[IRQ_W-1:0];
        OFS_IMSK:  n.imsk = wd[IRQ_W-1:0];
        default:   n.imsk = q.imsk;
      endcase
    end

    // Bus-busy tracking
    if (lm.stop_p) begin
      n.bb = 1'b0;
    end
    if (!lm.sda_lvl || !lm.scl_lvl || lm.start_p) begin
      n.bb = 1'b1;
    end

    // Start and stop end any match; start restarts address reception, stop returns to idle
    if (lm.start_p || lm.stop_p) begin
      n.match = 1'b0;
      n.gcm   = 1'b0;
    end
    if (lm.start_p) begin
      n.st = ST_ADDR;
      n.ist[IRQ_START] = 1'b1;
    end else if (lm.stop_p) begin
      n.st = ST_IDLE;
      n.ist[IRQ_STOP] = 1'b1;
    end else if (lm.byte_p && q.st == ST_ADDR) begin
      hit = !master_i && (addr_hit(lm.byte_val, q.oa1) ||
                          addr_hit(lm.byte_val, q.oa2));
      gh  = !master_i && q.ctl1[CTL1_GENERAL_CALL_ENABLE] &&
            (lm.byte_val == GCALL_ADR);
      n.match = hit;
      n.gcm   = gh;
      n.st    = (hit || gh) ? ST_SLAVE : ST_IDLE;
      if (hit) begin
        n.ist[IRQ_MATCH] = 1'b1;
      end
      if (gh) begin
        n.ist[IRQ_GCALL] = 1'b1;
      end
    end

    // Clock toggle: one cycle of high drive, then self-clear
    if (q.drv) begin
      n.drv = 1'b0;
      n.tgl = 1'b0;
      n.ist[IRQ_TGL] = 1'b1;
    end else if (q.tgl) begin
      n.drv = 1'b1;
    end

    // Disable clears control and status
    if (!n.ctl2[CTL2_EN]) begin
      n.st    = ST_IDLE;
      n.match = 1'b0;
      n.gcm   = 1'b0;
      n.bb    = 1'b0;
      n.tgl   = 1'b0;
      n.drv   = 1'b0;
      n.ctl1  = RST_BYTE;
    end

    n.busy = n.ctl2[CTL2_EN] &&
             (start_gen_i || master_i || n.match || n.gcm ||
              n.st == ST_ADDR);
    n.irq    = |(n.ist & n.imsk);
    n.scl_o  = n.drv;
    n.scl_oe = n.drv;

    // Read data registered with the answer
    if (rd) begin
      n.ack = 1'b1;
      case (wb_adr_i)
        OFS_CST:   n.dat = {24'h000000, cst};
        OFS_CTL1:  n.dat = {24'h000000, q.ctl1};
        OFS_CTL2:  n.dat = {24'h000000, q.ctl2};
        OFS_OADR1: n.dat = {24'h000000, q.oa1};
        OFS_OADR2: n.dat = {24'h000000, q.oa2};
        OFS_IST:   n.dat = {27'h0000000, q.ist};
        OFS_IMSK:  n.dat = {27'h0000000, q.imsk};
        default:   n.dat = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= T_RST;
    end else begin
      q <= n;
    end
  end

  assign wb_dat_o      = q.dat;
  assign wb_ack_o      = q.ack;
  assign scl_o         = q.scl_o;
  assign scl_oe        = q.scl_oe;
  assign module_busy_o = q.busy;
  assign irq_o         = q.irq;
endmodule

/* sim/bst_properties.sv */
`timescale 1ns/1ps
module bst_properties
  import bst_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        start_gen_i,
  input wire logic        master_i,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        module_busy_o
);
  logic wr;
  logic tgl_wr;
  logic en_q;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  assign wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign tgl_wr = wr && wb_adr_i == OFS_CST && wb_dat_i[CST_TGL];
  // Shadow of the module enable
  always_ff @(posedge clk) begin
    if (srst) begin
      en_q <= 1'b0;
    end else if (wr && wb_adr_i == OFS_CTL2) begin
      en_q <= wb_dat_i[CTL2_EN];
    end
  end
  chk_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  chk_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_rsvd_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == OFS_CST |-> wb_dat_o[31:6] == '0)
    else $error("upper status bits set");
  chk_busy_cause: assert property (
    en_q && !wr && (master_i || start_gen_i) |=> module_busy_o)
    else $error("busy missing");
  chk_off_quiet: assert property (
    !en_q && !$past(en_q) |-> !module_busy_o && !scl_oe)
    else $error("active while disabled");
  chk_tgl_pulse: assert property (
    $rose(scl_oe) |-> scl_o ##1 !scl_oe) else $error("bad clock pulse");
  chk_tgl_cause: assert property (
    $rose(scl_oe) |-> $past(tgl_wr, 2)) else $error("pulse without write");
  chk_rst_quiet: assert property (disable iff (1'b0)
    srst |=> !wb_ack_o && !module_busy_o && !scl_oe)
    else $error("active in reset");
endmodule
bind bst_top bst_properties i_chk (.clk(clk), .srst(srst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .start_gen_i(start_gen_i),
  .master_i(master_i), .scl_o(scl_o), .scl_oe(scl_oe),
  .module_busy_o(module_busy_o));

/* sim/bst_bus_model.sv */
`timescale 1ns/1ps
module bst_bus_model (
  input  wire logic clk,
  output logic      sda_low,
  output logic      scl_low
);
  initial begin
    sda_low = 1'b0;
    scl_low = 1'b0;
  end
  // Start, eight bits msb first, ack clock; clock then held low
  task automatic send_addr(input logic [7:0] a);
    @(negedge clk);
    sda_low = 1'b0;
    #40 scl_low = 1'b0;
    #40 sda_low = 1'b1;
    #40 scl_low = 1'b1;
    for (int i = 8; i >= 0; i--) begin
      sda_low = (i > 0) ? !a[i-1] : 1'b0;
      #40 scl_low = 1'b0;
      #80 scl_low = 1'b1;
      #40;
    end
    @(posedge clk);
  endtask
  task automatic send_stop();
    @(negedge clk);
    sda_low = 1'b1;
    #40 scl_low = 1'b0;
    #40 sda_low = 1'b0;
    #80;
    @(posedge clk);
  endtask
  task automatic lines(input logic s, input logic c);
    @(negedge clk);
    sda_low = s;
    scl_low = c;
    @(posedge clk);
  endtask
endmodule

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
  import bst_pkg::*;
  logic        clk;
  logic        srst;
  logic        cyc;
  logic        we;
  logic        sg;
  logic        mst;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] dat_o;
  logic [31:0] rdat;
  logic        ack;
  logic        scl_o;
  logic        scl_oe;
  logic        irq;
  logic        busy;
  logic        sda_low;
  logic        scl_low;
  int          bad_count;
  int          num_checks;
  logic [31:0] cfg [4] = '{32'h20aa5417, 32'h20aa001b, 32'h00aa0012,
                           32'h202a5412};
  bst_bus_model i_bus (.clk(clk), .sda_low(sda_low), .scl_low(scl_low));
  bst_top i_dut (
    .clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .start_gen_i(sg), .master_i(mst), .sda_i(!sda_low),
    .scl_i(!scl_low && !(scl_oe && !scl_o)), .scl_o(scl_o),
    .scl_oe(scl_oe), .module_busy_o(busy), .irq_o(irq));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      complete_run();
    end
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(rdat, {24'h0, exp});
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {srst, cyc, we, sg, mst, adr, wdat} = {1'b1, 44'h0};
    {bad_count, num_checks} = '0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(OFS_CST, 8'h00);
    bus(1'b1, OFS_CTL2, 8'h01);
    rd(OFS_CST, 8'h10);
    rd(8'h40, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, OFS_CTL1, cfg[i][31:24]);
      bus(1'b1, OFS_OADR1, cfg[i][23:16]);
      i_bus.send_addr(cfg[i][15:8]);
      rd(OFS_CST, cfg[i][7:0]);
      i_bus.send_stop();
      repeat (8) @(posedge clk);
      rd(OFS_CST, 8'h10);
      check({31'h0, irq}, 32'h0);
      bus(1'b1, OFS_IMSK, 8'h1f);
      check({31'h0, irq}, 32'h1);
      bus(1'b1, OFS_IST, 8'hff);
      check({31'h0, irq}, 32'h0);
      bus(1'b1, OFS_IMSK, 8'h00);
    end
    $display("test frames done");
    bus(1'b1, OFS_CTL1, 8'h20);
    bus(1'b1, OFS_OADR1, 8'haa);
    i_bus.send_addr(8'h00);
    i_bus.send_addr(8'h54);
    rd(OFS_CST, 8'h17);
    i_bus.lines(1'b0, 1'b0);
    repeat (8) @(posedge clk);
    bus(1'b1, OFS_CST, 8'h00);
    rd(OFS_CST, 8'h17);
    bus(1'b1, OFS_CST, 8'h02);
    rd(OFS_CST, 8'h15);
    bus(1'b1, OFS_CTL2, 8'h00);
    rd(OFS_CST, 8'h00);
    rd(OFS_CTL1, 8'h00);
    bus(1'b1, OFS_CTL2, 8'h01);
    rd(OFS_CST, 8'h10);
    for (int i = 0; i < 3; i++) begin
      {sg, mst} <= 2'(4'b0010 >> i);
      @(posedge clk);
      rd(OFS_CST, (i < 2) ? 8'h11 : 8'h10);
      check({31'h0, busy}, (i < 2) ? 32'h1 : 32'h0);
    end
    $display("test flags done");
    bus(1'b1, OFS_CST, 8'h20);
    rd(OFS_CST, 8'h10);
    i_bus.lines(1'b1, 1'b0);
    repeat (8) @(posedge clk);
    rd(OFS_CST, 8'h03);
    bus(1'b1, OFS_CST, 8'h20);
    @(posedge clk);
    check({31'h0, scl_oe}, 32'h1);
    rd(OFS_CST, 8'h03);
    $display("test toggle done");
    complete_run();
  end
endmodule
